// >>> sdl_host_model.sv
// host model driving the serial write port
`timescale 1ns/1ps
module sdl_host_model (
   input  wire logic ref_clk,
   input  wire logic ser_dout,
   output logic      ser_clk,
   output logic      ser_din,
   output logic      enable_n,
   output logic      target_pick
);
   logic [159:0] outs;
   initial begin
      ser_clk = 1'b0;
      ser_din = 1'b0;
      enable_n = 1'b1;
      target_pick = 1'b0;
   end
   task automatic tick(input int k);
      repeat (k) @(posedge ref_clk);
      #1;
   endtask
   // msb first; act low clocks with enable held high
   task automatic send(input logic pick, input logic [159:0] v,
                       input int n, input logic act);
      target_pick = pick;
      tick(4);
      enable_n = ~act;
      tick(4);
      target_pick = ~pick;
      for (int i = n - 1; i >= 0; i--) begin
         ser_din = v[i];
         tick(8);
         ser_clk = 1'b1;
         tick(8);
         outs = {outs[158:0], ser_dout};
         ser_clk = 1'b0;
      end
      ser_din = ~ser_din;
      enable_n = 1'b1;
      tick(12);
   endtask
endmodule

// >>> sdl_loader.sv
// serial dot display loader: serial port, control words, display clock
`timescale 1ns/1ps
module sdl_loader
   import sdl_pkg::*;
#(
   parameter int DOTS     = DOT_BITS,
   parameter int OSC_HALF = OSC_HALF_CYC
) (
   input  wire logic                ref_clk,
   input  wire logic                nrst,
   input  wire logic                ser_clk,
   input  wire logic                ser_din,
   input  wire logic                enable_n,
   input  wire logic                target_pick,
   input  wire logic                osc_select,
   input  wire logic                dark_force,
   input  wire logic                display_clock_pin_in,
   output logic                     display_clock_pin_out,
   output logic                     display_clock_pin_oe,
   output logic                     ser_dout,
   output logic [DOTS-1:0]          led_drive,
   output logic [PEAK_W-1:0]        led_peak_current,
   output logic                     ref_current_on,
   output logic [CTL_BITS-1:0]      ctl_word1
);
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [SYNC_W-1:0] pins_sync;
   logic s_clk, s_din, s_en_n, s_pick, s_osel, s_dark, s_xosc;
   logic s_en;

   sdl_sync #(.W(SYNC_W)) u_sync (
      .ref_clk  (ref_clk),
      .nrst     (nrst),
      .pin_in   ({display_clock_pin_in, dark_force, osc_select,
                  target_pick, ~enable_n, ser_din, ser_clk}),
      .pin_sync (pins_sync)
   );
   // enable synced active high so reset reads as idle
   assign {s_xosc, s_dark, s_osel, s_pick, s_en, s_din, s_clk} = pins_sync;
   assign s_en_n = ~s_en;

   // ----------------------------------------
   // control state
   // ----------------------------------------
   sdl_state_t                state_reg, state_next;
   logic                      clk_prev_reg, clk_prev_next;
   logic                      pick_reg, pick_next;
   logic [CTL_SHIFT_BITS-1:0] cshift_reg, cshift_next;
   logic [CTL_BITS-1:0]       word0_reg, word0_next;
   logic [CTL_BITS-1:0]       word1_reg, word1_next;
   logic                      dout_reg, dout_next;
   logic [15:0]               osc_cnt_reg, osc_cnt_next;
   logic                      osc_reg, osc_next;
   logic                      dclk_prev_reg, dclk_prev_next;
   logic [BRIGHT_W-1:0]       pwm_reg, pwm_next;
   logic                      commit_dots;
   logic                      awake;
   logic                      clk_rise;
   logic                      dclk;
   logic [DOTS-1:0]           dshift_reg, dshift_next;
   logic [DOTS-1:0]           dlatch_reg, dlatch_next;
   logic [DOTS-1:0]           drive_reg, drive_next;

   assign awake    = word0_reg[AWAKE_POS];
   assign clk_rise = s_clk & ~clk_prev_reg;
   assign dclk     = s_osel ? osc_reg : s_xosc;

   // ----------------------------------------
   // transfer, oscillator and pwm next state
   // ----------------------------------------

   always_comb begin
      state_next     = state_reg;
      clk_prev_next  = s_clk;
      pick_next      = pick_reg;
      cshift_next    = cshift_reg;
      word0_next     = word0_reg;
      word1_next     = word1_reg;
      dout_next      = dout_reg;
      commit_dots    = 1'b0;
      osc_cnt_next   = osc_cnt_reg;
      osc_next       = osc_reg;
      dclk_prev_next = dclk;
      pwm_next       = pwm_reg;
      case (state_reg)
         SDL_IDLE: begin
            if (!s_en_n) begin
               pick_next  = s_pick;
               state_next = SDL_SHIFT;
            end
         end
         SDL_SHIFT: begin
            if (s_en_n) begin
               state_next = SDL_COMMIT;
            end else if (clk_rise && pick_reg) begin
               cshift_next = {cshift_reg[CTL_SHIFT_BITS-2:0], s_din};
               dout_next   = cshift_reg[CTL_SHIFT_BITS-1];
            end else if (clk_rise) begin
               dout_next = dshift_reg[DOTS-1];
            end
         end
         SDL_COMMIT: begin
            if (!s_en_n) begin
               pick_next  = s_pick;
               state_next = SDL_SHIFT;
            end else if (!s_clk) begin
               state_next = SDL_IDLE;
               if (!pick_reg) begin
                  commit_dots = 1'b1;
               end else if (cshift_reg[CTL_WSEL_POS]) begin
                  word1_next = cshift_reg[CTL_BITS-1:0];
               end else begin
                  word0_next = cshift_reg[CTL_BITS-1:0];
               end
            end
         end
         default: state_next = SDL_IDLE;
      endcase
      // internal oscillator halts while asleep
      if (!awake || !s_osel) begin
         osc_cnt_next = 16'h0000;
         osc_next     = 1'b0;
      end else if (osc_cnt_reg == 16'(OSC_HALF - 1)) begin
         osc_cnt_next = 16'h0000;
         osc_next     = ~osc_reg;
      end else begin
         osc_cnt_next = osc_cnt_reg + 16'h0001;
      end
      if (dclk && !dclk_prev_reg) begin
         pwm_next = pwm_reg + 4'h1;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         state_reg     <= SDL_IDLE;
         clk_prev_reg  <= 1'b0;
         pick_reg      <= 1'b0;
         cshift_reg    <= 8'h00;
         word0_reg     <= CTL_RESET;
         word1_reg     <= CTL_RESET;
         dout_reg      <= 1'b0;
         osc_cnt_reg   <= 16'h0000;
         osc_reg       <= 1'b0;
         dclk_prev_reg <= 1'b0;
         pwm_reg       <= 4'h0;
         drive_reg     <= '0;
      end else begin
         state_reg     <= state_next;
         clk_prev_reg  <= clk_prev_next;
         pick_reg      <= pick_next;
         cshift_reg    <= cshift_next;
         word0_reg     <= word0_next;
         word1_reg     <= word1_next;
         dout_reg      <= dout_next;
         osc_cnt_reg   <= osc_cnt_next;
         osc_reg       <= osc_next;
         dclk_prev_reg <= dclk_prev_next;
         pwm_reg       <= pwm_next;
         drive_reg     <= drive_next;
      end
   end

   // ----------------------------------------
   // pixel shift register and latch
   // ----------------------------------------
   always_comb begin
      dshift_next = dshift_reg;
      dlatch_next = dlatch_reg;
      if (state_reg == SDL_SHIFT && !s_en_n && clk_rise && !pick_reg) begin
         dshift_next = {dshift_reg[DOTS-2:0], s_din};
      end
      if (commit_dots) begin
         dlatch_next = dshift_reg;
      end
      if (!awake || s_dark
          || pwm_reg > word0_reg[BRIGHT_LSB +: BRIGHT_W]) begin
         drive_next = '0;
      end else begin
         drive_next = dlatch_reg;
      end
   end

   // no reset here: pixel contents survive reset
   always_ff @(posedge ref_clk) begin
      dshift_reg <= dshift_next;
      dlatch_reg <= dlatch_next;
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign display_clock_pin_out = osc_reg;
   assign display_clock_pin_oe  = s_osel;
   assign ser_dout              = dout_reg;
   assign led_drive             = drive_reg;
   assign led_peak_current      = word0_reg[PEAK_LSB +: PEAK_W];
   assign ref_current_on        = awake;
   assign ctl_word1             = word1_reg;
endmodule

// >>> sdl_loader_properties.sv
// checker for the serial dot display loader
`timescale 1ns/1ps
module sdl_loader_properties
   import sdl_pkg::*;
#(parameter int DOTS = DOT_BITS) (
   input wire logic                ref_clk,
   input wire logic                nrst,
   input wire logic                enable_n,
   input wire logic                osc_select,
   input wire logic                dark_force,
   input wire logic                display_clock_pin_out,
   input wire logic                display_clock_pin_oe,
   input wire logic                ser_dout,
   input wire logic [DOTS-1:0]     led_drive,
   input wire logic [PEAK_W-1:0]   led_peak_current,
   input wire logic                ref_current_on,
   input wire logic [CTL_BITS-1:0] ctl_word1
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   property p_rst; disable iff (1'b0)
      !nrst |-> {ref_current_on, led_peak_current, ctl_word1} == '0;
   endproperty
   a_rst: assert property (p_rst) else $error("ctl not cleared");
   property p_oe; $rose(osc_select) |-> ##[1:4] display_clock_pin_oe;
   endproperty
   a_oe: assert property (p_oe) else $error("pin not driven");
   property p_ext; (!display_clock_pin_oe)[*3] |-> !display_clock_pin_out;
   endproperty
   a_ext: assert property (p_ext) else $error("pin out active");
   property p_sleep; (!ref_current_on)[*2] |-> !display_clock_pin_out;
   endproperty
   a_sleep: assert property (p_sleep) else $error("osc runs");
   property p_dark; dark_force[*4] |-> led_drive == '0; endproperty
   a_dark: assert property (p_dark) else $error("leds lit");
   property p_asleep; (!ref_current_on)[*2] |-> led_drive == '0;
   endproperty
   a_asleep: assert property (p_asleep) else $error("lit asleep");
   property p_commit; $changed({ctl_word1, led_peak_current})
      |-> enable_n && $past(enable_n, 2); endproperty
   a_commit: assert property (p_commit) else $error("early");
   property p_quiet; enable_n[*8] |-> $stable(ser_dout); endproperty
   a_quiet: assert property (p_quiet) else $error("dout moved");
endmodule
bind sdl_loader sdl_loader_properties #(.DOTS(DOTS)) sdl_props_inst (
   .ref_clk, .nrst, .enable_n, .osc_select, .dark_force,
   .display_clock_pin_out, .display_clock_pin_oe, .ser_dout,
   .led_drive, .led_peak_current, .ref_current_on, .ctl_word1);

// >>> sdl_loader_tb.sv
// testbench for the serial dot display loader
`timescale 1ns/1ps
module sdl_loader_tb;
   import sdl_pkg::*;
   localparam logic [159:0] PA = {5{32'hc3a50f96}};
   localparam logic [159:0] PB = {5{32'h5a3ce187}};
   logic                ref_clk;
   logic                nrst;
   logic                osc_select;
   logic                dark_force;
   logic                ext_clk;
   logic                osc_seen;
   logic                ser_clk;
   logic                ser_din;
   logic                enable_n;
   logic                target_pick;
   logic                pin_out;
   logic                pin_oe;
   logic                ser_dout;
   logic                awake;
   logic [159:0]        led;
   logic [PEAK_W-1:0]   peak;
   logic [CTL_BITS-1:0] word1;
   int                  n_fail = 0;
   int                  num_checks = 0;
   wire pin = pin_oe ? pin_out : ext_clk;
   always #5 ref_clk = ~ref_clk;
   always #40 ext_clk = ~ext_clk;
   sdl_loader #(.OSC_HALF(2)) sdl_loader_inst (.ref_clk, .nrst, .ser_clk,
      .ser_din, .enable_n, .target_pick, .osc_select, .dark_force,
      .display_clock_pin_in(pin), .display_clock_pin_out(pin_out),
      .display_clock_pin_oe(pin_oe), .ser_dout, .led_drive(led),
      .led_peak_current(peak), .ref_current_on(awake), .ctl_word1(word1));
   sdl_host_model sdl_host_model_inst (.ref_clk, .ser_dout, .ser_clk,
      .ser_din, .enable_n, .target_pick);
   task automatic chk(input logic [159:0] got, input logic [159:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d fails %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic ctl(input logic [7:0] w);
      sdl_host_model_inst.send(1'b1, {152'h0, w}, 8, 1'b1);
   endtask
   task automatic dots(input logic [159:0] p);
      sdl_host_model_inst.send(1'b0, p, 160, 1'b1);
   endtask
   initial begin
      #400000;
      n_fail++;
      print_verdict();
   end
   initial begin
      ref_clk    = 1'b0;
      ext_clk    = 1'b0;
      osc_select = 1'b1;
      dark_force = 1'b0;
      #1;
      nrst = 1'b0;
      sdl_host_model_inst.tick(2);
      nrst = 1'b1;
      chk({awake, peak, word1}, 0);
      dots(PA);
      chk(led, 0);
      ctl(8'h6f);
      chk({awake, peak}, 3'h6);
      chk(led, PA);
      ctl(8'hd5);
      chk({peak, word1}, 9'h155);
      $display("control test done");
      fork
         dots(PB);
         begin
            sdl_host_model_inst.tick(1000);
            chk(led, PA);
         end
      join
      chk(led, PB);
      chk(sdl_host_model_inst.outs, PA);
      sdl_host_model_inst.send(1'b0, PA, 8, 1'b0);
      chk(led, PB);
      nrst = 1'b0;
      sdl_host_model_inst.tick(2);
      chk({awake, peak, word1}, 0);
      chk(led, 0);
      nrst = 1'b1;
      ctl(8'h4f);
      chk(led, PB);
      dark_force = 1'b1;
      sdl_host_model_inst.tick(6);
      chk(led, 0);
      dark_force = 1'b0;
      chk(pin_oe, 1'b1);
      osc_select = 1'b0;
      sdl_host_model_inst.tick(6);
      chk({pin_oe, pin_out}, 0);
      $display("reset and pin test done");
      dots(PA);
      chk(sdl_host_model_inst.outs, PB);
      chk(led, PA);
      osc_select = 1'b1;
      sdl_host_model_inst.tick(6);
      chk(pin_oe, 1'b1);
      osc_seen = pin_out;
      sdl_host_model_inst.tick(2);
      chk(pin_out, {159'h0, ~osc_seen});
      $display("chain test done");
      print_verdict();
   end
endmodule

// >>> sdl_pkg.sv
// shared constants for the serial dot display loader
package sdl_pkg;
   // ----------------------------------------
   // geometry
   // ----------------------------------------
   localparam int DOT_BITS       = 160;
   localparam int CTL_BITS       = 7;
   localparam int CTL_SHIFT_BITS = 8;
   localparam int CTL_WSEL_POS   = 7;
   // ----------------------------------------
   // control word 0 fields
   // ----------------------------------------
   localparam int BRIGHT_LSB  = 0;
   localparam int BRIGHT_W    = 4;
   localparam int PEAK_LSB    = 4;
   localparam int PEAK_W      = 2;
   localparam int AWAKE_POS   = 6;
   localparam logic [6:0] CTL_RESET = 7'h00;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_MHZ        = 100;
   localparam int OSC_FREQ_KHZ   = 200;
   localparam int OSC_HALF_CYC   = (CLK_MHZ * 1000) / (2 * OSC_FREQ_KHZ);
   localparam int SYNC_W         = 7;
   // ----------------------------------------
   // transfer states
   // ----------------------------------------
   typedef enum logic [1:0] {SDL_IDLE, SDL_SHIFT, SDL_COMMIT} sdl_state_t;
endpackage

// >>> sdl_sync.sv
// two flip-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
module sdl_sync #(
   parameter int W = 1
) (
   input  wire logic         ref_clk,
   input  wire logic         nrst,
   input  wire logic [W-1:0] pin_in,
   output logic      [W-1:0] pin_sync
);
   logic [W-1:0] stage1_reg;
   logic [W-1:0] stage2_reg;

   // ----------------------------------------
   // per bit two stages
   // ----------------------------------------
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge ref_clk or negedge nrst) begin
            if (!nrst) begin
               stage1_reg[i] <= 1'b0;
               stage2_reg[i] <= 1'b0;
            end else begin
               stage1_reg[i] <= pin_in[i];
               stage2_reg[i] <= stage1_reg[i];
            end
         end
      end
   endgenerate

   assign pin_sync = stage2_reg;
endmodule
